// ### shared/fbci_pkg.sv
// Purpose: Constants and types shared by the flash host controller files
// Assumes: 200 MHz sys_clk, byte-wide flash with 18 address lines
// Notes: Pulse and cycle times are minimums; counts round up
package fbci_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_PS = 5000;
  // Bus phase timing, in ps as a whole figure
  localparam int T_SETUP_PS = 50000;
  localparam int T_STROBE_PS = 100000;
  localparam int T_HOLD_PS = 50000;
  localparam int T_ACCESS_PS = 150000;
  localparam int SETUP_CYC = (T_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STROBE_CYC = (T_STROBE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_CYC = (T_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACCESS_CYC = (T_ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 16;
  // Command register values
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_VFY = 8'hA0;
  localparam logic [7:0] CMD_PROG = 8'h40;
  localparam logic [7:0] CMD_PROG_VFY = 8'hC0;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam int ADDR_BIT_ZERO = 0;
  localparam int ADDR_BIT_NINE = 9;
  typedef enum logic [2:0] {
    FBCI_OP_READ = 3'h0,
    FBCI_OP_WRITE = 3'h1,
    FBCI_OP_IDENT_PIN = 3'h2,
    FBCI_OP_IDLE = 3'h3
  } fbci_op_e;
endpackage

// ### shared/fbci_cyc_if.sv
// Purpose: Carries one bus cycle request between sequencer and pin driver
// Assumes: Single clock, sys_clk
// Notes: Request held while valid and not ready
`timescale 1ns/100ps
interface fbci_cyc_if;
  import fbci_pkg::*;
  logic valid;
  logic ready;
  fbci_op_e op;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic done;
  modport seq (output valid, output op, output addr, output wdata,
    input ready, input rdata, input done);
  modport pin (input valid, input op, input addr, input wdata,
    output ready, output rdata, output done);
endinterface

// ### hw/fbci_pin_drv.sv
// Purpose: Drives one flash bus cycle on the pins with fixed phase timing
// Assumes: Flash pins sampled synchronously to sys_clk
// Notes: Address set from the setup phase, before strobe fall; data held until after strobe rise
`timescale 1ns/100ps
module fbci_pin_drv
  import fbci_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  fbci_cyc_if.pin cyc,
  output logic chip_sel_n,
  output logic out_gate_n,
  output logic wr_strobe_n,
  output logic [ADDR_W-1:0] addr_out,
  output logic id_volt_en,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [DATA_W-1:0] dq_i
);
  typedef enum logic [3:0] {
    PD_IDLE = 4'b0001, PD_SETUP = 4'b0010, PD_STROBE = 4'b0100, PD_HOLD = 4'b1000
  } fbci_pd_e;
  typedef struct packed {
    fbci_pd_e st;
    logic [CNT_W-1:0] cnt;
    fbci_op_e op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic done;
  } fbci_pd_s;
  fbci_pd_s s_r, s_nxt;
  localparam logic [CNT_W-1:0] SETUP_N = CNT_W'(SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] STROBE_N = CNT_W'(STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] ACCESS_N = CNT_W'(ACCESS_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_N = CNT_W'(HOLD_CYC - 1);
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    unique case (s_r.st)
      PD_IDLE: begin
        if (cyc.valid) begin
          s_nxt.op = cyc.op;
          s_nxt.addr = cyc.addr;
          s_nxt.wdata = cyc.wdata;
          s_nxt.cnt = SETUP_N;
          s_nxt.st = PD_SETUP;
        end
      end
      PD_SETUP: begin
        if (s_r.cnt == '0) begin
          s_nxt.cnt = (s_r.op == FBCI_OP_WRITE) ? STROBE_N : ACCESS_N;
          s_nxt.st = PD_STROBE;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      PD_STROBE: begin
        if (s_r.cnt == '0) begin
          s_nxt.rdata = dq_i;
          s_nxt.cnt = HOLD_N;
          s_nxt.st = PD_HOLD;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      PD_HOLD: begin
        if (s_r.cnt == '0) begin
          s_nxt.done = 1'b1;
          s_nxt.st = PD_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      default: s_nxt.st = PD_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '{st: PD_IDLE, cnt: '0, op: FBCI_OP_IDLE, addr: '0, wdata: '0,
        rdata: '0, done: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end
  wire active = (s_r.st != PD_IDLE);
  wire is_wr = (s_r.op == FBCI_OP_WRITE);
  assign cyc.ready = (s_r.st == PD_IDLE);
  assign cyc.rdata = s_r.rdata;
  assign cyc.done = s_r.done;
  assign chip_sel_n = !active;
  // Write keeps the output gate high so the flash never drives against us
  assign out_gate_n = !(active && !is_wr);
  assign wr_strobe_n = !(is_wr && s_r.st == PD_STROBE);
  assign addr_out = active ? s_r.addr : '0;
  assign id_volt_en = active && s_r.op == FBCI_OP_IDENT_PIN;
  assign dq_o = is_wr ? s_r.wdata : '0;
  // Data driven across the strobe rise and through hold
  assign dq_oe = is_wr && (s_r.st == PD_STROBE || s_r.st == PD_HOLD);
  a_wr_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !wr_strobe_n |-> (!chip_sel_n && out_gate_n && dq_oe))
    else $error("strobe low without select, gate high and data");
  a_hold_data: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(wr_strobe_n) |-> dq_oe && $stable(dq_o))
    else $error("data not held at strobe rise");
endmodule

// ### hw/fbci_host.sv
// Purpose: Host controller issuing flash commands and bus cycles via pins
// Assumes: Program supply switch driven by this block; pins synchronous
// Notes: Erase/program pulse length set by gap to the verify write
`timescale 1ns/100ps
module fbci_host
  import fbci_pkg::*;
#(
  parameter int PULSE_W = 24
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire fbci_pkg::fbci_op_e req_kind,
  input wire logic [2:0] req_cmd,
  input wire logic [fbci_pkg::ADDR_W-1:0] req_addr,
  input wire logic [fbci_pkg::DATA_W-1:0] req_data,
  input wire logic [PULSE_W-1:0] req_pulse,
  input wire logic supply_high_req,
  output logic resp_valid,
  output logic resp_err,
  output logic [fbci_pkg::DATA_W-1:0] resp_data,
  output logic prog_supply_en,
  output logic chip_sel_n,
  output logic out_gate_n,
  output logic wr_strobe_n,
  output logic [fbci_pkg::ADDR_W-1:0] flash_addr,
  output logic id_volt_en,
  output logic [fbci_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [fbci_pkg::DATA_W-1:0] dq_i
);
  import fbci_pkg::*;
  // Operation codes on req_cmd when req_kind is FBCI_OP_WRITE
  localparam logic [2:0] HC_READ = 3'h0;
  localparam logic [2:0] HC_IDENT = 3'h1;
  localparam logic [2:0] HC_ERASE = 3'h2;
  localparam logic [2:0] HC_PROG = 3'h3;
  localparam logic [2:0] HC_RESET = 3'h4;
  typedef enum logic [5:0] {
    HS_IDLE = 6'b000001, HS_WR1 = 6'b000010, HS_WR2 = 6'b000100,
    HS_PULSE = 6'b001000, HS_VFY = 6'b010000, HS_RD = 6'b100000
  } fbci_hs_e;
  typedef struct packed {
    fbci_hs_e st;
    logic [2:0] cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [PULSE_W-1:0] cnt;
    logic supply;
    logic issued;
    logic resp_valid;
    logic resp_err;
    logic [DATA_W-1:0] resp_data;
  } fbci_hs_s;
  fbci_hs_s s_r, s_nxt;
  fbci_cyc_if cyc();
  function automatic logic alters_array(input logic [2:0] c);
    return c == HC_ERASE || c == HC_PROG;
  endfunction
  function automatic logic [7:0] first_byte(input logic [2:0] c);
    unique case (c)
      HC_READ: return CMD_READ;
      HC_IDENT: return CMD_IDENT;
      HC_ERASE: return CMD_ERASE;
      HC_PROG: return CMD_PROG;
      default: return CMD_RESET;
    endcase
  endfunction
  wire is_cmd = req_kind == FBCI_OP_WRITE;
  // Array changes refused while supply low, the flash would ignore them
  wire refuse = is_cmd && alters_array(req_cmd) && !s_r.supply;
  always_comb begin
    s_nxt = s_r;
    s_nxt.resp_valid = 1'b0;
    s_nxt.issued = s_r.issued;
    // Supply only changes between sequences, never as a request is taken
    if (s_r.st == HS_IDLE && !req_valid) begin
      s_nxt.supply = supply_high_req;
    end
    unique case (s_r.st)
      HS_IDLE: begin
        s_nxt.issued = 1'b0;
        if (req_valid) begin
          s_nxt.cmd = req_cmd;
          s_nxt.addr = req_addr;
          s_nxt.data = req_data;
          s_nxt.cnt = req_pulse;
          if (refuse) begin
            s_nxt.resp_valid = 1'b1;
            s_nxt.resp_err = 1'b1;
          end else if (is_cmd && !s_r.supply) begin
            s_nxt.resp_valid = 1'b1;
            s_nxt.resp_err = 1'b1;
          end else begin
            s_nxt.resp_err = 1'b0;
            s_nxt.st = is_cmd ? HS_WR1 : HS_RD;
          end
        end
      end
      HS_WR1: begin
        if (cyc.done) begin
          s_nxt.issued = 1'b0;
          s_nxt.st = (s_r.cmd == HC_READ || s_r.cmd == HC_IDENT) ? HS_IDLE : HS_WR2;
          s_nxt.resp_valid = (s_r.cmd == HC_READ || s_r.cmd == HC_IDENT);
        end else if (cyc.ready) begin
          s_nxt.issued = 1'b1;
        end
      end
      HS_WR2: begin
        if (cyc.done) begin
          s_nxt.issued = 1'b0;
          s_nxt.st = alters_array(s_r.cmd) ? HS_PULSE : HS_IDLE;
          s_nxt.resp_valid = !alters_array(s_r.cmd);
        end else if (cyc.ready) begin
          s_nxt.issued = 1'b1;
        end
      end
      HS_PULSE: begin
        // Pulse is a minimum; extra cycles are harmless thanks to stop timer
        if (s_r.cnt == '0) begin
          s_nxt.st = HS_VFY;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      HS_VFY: begin
        if (cyc.done) begin
          s_nxt.issued = 1'b0;
          s_nxt.cmd = HC_READ;
          s_nxt.st = HS_RD;
        end else if (cyc.ready) begin
          s_nxt.issued = 1'b1;
        end
      end
      HS_RD: begin
        if (cyc.done) begin
          s_nxt.resp_data = cyc.rdata;
          s_nxt.resp_valid = 1'b1;
          s_nxt.st = HS_IDLE;
        end else if (cyc.ready) begin
          s_nxt.issued = 1'b1;
        end
      end
      default: s_nxt.st = HS_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '{st: HS_IDLE, cmd: HC_READ, addr: '0, data: '0, cnt: '0, supply: 1'b0,
        issued: 1'b0, resp_valid: 1'b0, resp_err: 1'b0, resp_data: '0};
    end else begin
      s_r <= s_nxt;
    end
  end
  logic rd_ident;
  logic [DATA_W-1:0] wr_val;
  always_comb begin
    rd_ident = 1'b0;
    wr_val = first_byte(s_r.cmd);
    cyc.op = FBCI_OP_READ;
    if (s_r.st == HS_RD && req_kind == FBCI_OP_IDENT_PIN) begin
      rd_ident = 1'b1;
    end
    if (s_r.st == HS_WR2) begin
      // Program second cycle carries address and data to be latched
      wr_val = (s_r.cmd == HC_PROG) ? s_r.data : first_byte(s_r.cmd);
    end else if (s_r.st == HS_VFY) begin
      wr_val = (s_r.cmd == HC_PROG) ? CMD_PROG_VFY : CMD_ERASE_VFY;
    end
    if (s_r.st == HS_WR1 || s_r.st == HS_WR2 || s_r.st == HS_VFY) begin
      cyc.op = FBCI_OP_WRITE;
    end else if (rd_ident) begin
      cyc.op = FBCI_OP_IDENT_PIN;
    end
  end
  // Pin identifier uses only bit zero and elevated bit nine
  assign cyc.addr = rd_ident ?
    ADDR_W'({s_r.addr[ADDR_BIT_ZERO]} << ADDR_BIT_ZERO) : s_r.addr;
  assign cyc.wdata = wr_val;
  assign cyc.valid = (s_r.st inside {HS_WR1, HS_WR2, HS_VFY, HS_RD}) && !s_r.issued;
  fbci_pin_drv u_drv (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .cyc(cyc),
    .chip_sel_n(chip_sel_n),
    .out_gate_n(out_gate_n),
    .wr_strobe_n(wr_strobe_n),
    .addr_out(flash_addr),
    .id_volt_en(id_volt_en),
    .dq_o(dq_o),
    .dq_oe(dq_oe),
    .dq_i(dq_i)
  );
  assign req_ready = s_r.st == HS_IDLE;
  assign resp_valid = s_r.resp_valid;
  assign resp_err = s_r.resp_err;
  assign resp_data = s_r.resp_data;
  assign prog_supply_en = s_r.supply;
  a_no_wr_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !wr_strobe_n |-> prog_supply_en)
    else $error("write strobe with supply low");
  a_refuse: assert property (@(posedge sys_clk) disable iff (sys_rst)
    req_ready && req_valid && refuse |=> resp_valid && resp_err && req_ready)
    else $error("array request with supply low not refused");
  a_vfy_after_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_r.st == HS_PULSE && s_r.cnt == '0 |=> s_r.st == HS_VFY ##[1:80] !wr_strobe_n)
    else $error("verify write not issued after pulse");
  a_supply_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !req_ready |=> $stable(prog_supply_en))
    else $error("supply changed mid sequence");
  a_id_addr: assert property (@(posedge sys_clk) disable iff (sys_rst)
    id_volt_en |-> flash_addr[ADDR_W-1:1] == '0 && out_gate_n == 1'b0)
    else $error("identifier read with other address bits high");
  a_float: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !out_gate_n |-> !dq_oe)
    else $error("host drives data while flash outputs enabled");
endmodule

// ### testbench/fbci_flash_model.sv
// Purpose: Behavioural flash device seen at the host controller's pins
// Assumes: Host pins change on sys_clk edges; 5 ns clock for pulse checks
// Notes: Codes are arbitrary; a floated bus shows the inverse of its last value
`timescale 1ns/100ps
module fbci_flash_model
  import fbci_pkg::*;
#(
  parameter logic [7:0] MFR_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hC3 // Arbitrary value
)
(
  input wire logic supply_hi,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [fbci_pkg::ADDR_W-1:0] addr,
  input wire logic id_hv,
  input wire logic [fbci_pkg::DATA_W-1:0] din,
  input wire logic din_oe,
  input wire logic [23:0] pulse_cyc,
  output logic [fbci_pkg::DATA_W-1:0] dout,
  output logic fault
);
  logic [7:0] mem [logic [ADDR_W-1:0]];
  logic [7:0] cmd_r = CMD_READ;
  logic [7:0] val;
  logic [7:0] last = 8'h00;
  logic [ADDR_W-1:0] a_lat;
  logic [ADDR_W-1:0] pa_r;
  logic rd;
  realtime t_pulse;
  logic fault_wr = 1'b0;
  logic fault_pin = 1'b0;
  assign fault = fault_wr | fault_pin;
  function automatic logic [7:0] rdm(input logic [ADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  always @(negedge we_n) if (!ce_n) a_lat = addr;
  // Writes count only with high supply, selected and gate high
  always @(negedge supply_hi or posedge we_n) begin
    if (!supply_hi) begin
      cmd_r = CMD_READ;
    end else if (!ce_n && oe_n) begin
      if (cmd_r == CMD_PROG) begin
        mem[a_lat] = rdm(a_lat) & din;
        pa_r = a_lat;
        cmd_r = 8'h01;
        t_pulse = $realtime;
      end else if (cmd_r == CMD_ERASE) begin
        if (din == CMD_ERASE) mem.delete();
        cmd_r = 8'h01;
        t_pulse = $realtime;
      end else begin
        // Stop timer may have idled us; only verify or reset leave the pulse
        if (cmd_r == 8'h01 && din != CMD_PROG_VFY && din != CMD_ERASE_VFY &&
          din != CMD_RESET) fault_wr = 1'b1;
        if (cmd_r == 8'h01 && ($realtime - t_pulse) < pulse_cyc * 5.0) fault_wr = 1'b1;
        if (din == CMD_ERASE_VFY) pa_r = a_lat;
        cmd_r = din;
      end
    end
  end
  always_comb begin
    rd = !ce_n && !oe_n;
    if (id_hv) val = addr[0] ? DEV_CODE : MFR_CODE;
    else if (cmd_r == CMD_IDENT) val = addr[0] ? DEV_CODE : MFR_CODE;
    else if (cmd_r == CMD_PROG_VFY || cmd_r == CMD_ERASE_VFY) val = rdm(pa_r);
    else val = rdm(addr);
  end
  always @(val) if (rd) last = val;
  assign dout = rd ? val : ~last;
  always @* if ((din_oe && rd) || (id_hv && !ce_n && |addr[ADDR_W-1:1]))
    fault_pin = 1'b1;
endmodule

// ### testbench/flash_bus_command_interface_tb_top.sv
// Purpose: Self-checking bench for the flash host controller
// Assumes: Inputs driven at falling sys_clk edge; fixed seed
// Notes: Expected array kept in the bench; programming only clears bits
`timescale 1ns/100ps
module flash_bus_command_interface_tb_top;
  import fbci_pkg::*;
  logic sys_clk, sys_rst, req_valid, supply_high_req;
  fbci_op_e req_kind;
  logic [2:0] req_cmd;
  logic [ADDR_W-1:0] req_addr;
  logic [7:0] req_data;
  logic [23:0] req_pulse;
  logic req_ready, resp_valid, resp_err, prog_supply_en, chip_sel_n, out_gate_n;
  logic wr_strobe_n, id_volt_en, dq_oe, fault;
  logic [7:0] resp_data, dq_o, flash_dq;
  logic [ADDR_W-1:0] flash_addr;
  logic [7:0] exp_mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] alist [4];
  int num_errors = 0;
  int tests_run = 0;
  int seed;
  fbci_host DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_kind(req_kind), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_data(req_data), .req_pulse(req_pulse), .supply_high_req(supply_high_req),
    .resp_valid(resp_valid), .resp_err(resp_err), .resp_data(resp_data),
    .prog_supply_en(prog_supply_en), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n),
    .wr_strobe_n(wr_strobe_n), .flash_addr(flash_addr), .id_volt_en(id_volt_en),
    .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(flash_dq));
  fbci_flash_model flash (.supply_hi(prog_supply_en), .ce_n(chip_sel_n), .oe_n(out_gate_n),
    .we_n(wr_strobe_n), .addr(flash_addr), .id_hv(id_volt_en), .din(dq_o), .din_oe(dq_oe),
    .pulse_cyc(req_pulse), .dout(flash_dq), .fault(fault));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic [7:0] exp_rd(input logic [ADDR_W-1:0] a);
    return exp_mem.exists(a) ? exp_mem[a] : 8'hFF;
  endfunction
  task automatic summarize();
    $display("Counts: %0d checks, %0d mismatches", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic run(input fbci_op_e k, input logic [2:0] c, input logic [ADDR_W-1:0] a,
    input logic [7:0] d, input logic [23:0] p);
    int i;
    @(negedge sys_clk);
    req_kind = k;
    req_cmd = c;
    req_addr = a;
    req_data = d;
    req_pulse = p;
    req_valid = 1'b1;
    for (i = 0; i < 5000 && req_ready !== 1'b1; i++) @(negedge sys_clk);
    if (req_ready !== 1'b1) begin
      num_errors++;
      $display("MISMATCH t=%0t request never taken", $time);
      summarize();
    end
    @(negedge sys_clk);
    req_valid = 1'b0;
    for (i = 0; i < 5000 && resp_valid !== 1'b1; i++) @(negedge sys_clk);
    if (resp_valid !== 1'b1) begin
      num_errors++;
      $display("MISMATCH t=%0t no response", $time);
      summarize();
    end
  endtask
  // Pin level watch on every write strobe
  always @(negedge sys_clk) begin
    if (!sys_rst && !wr_strobe_n && (chip_sel_n || !out_gate_n || !prog_supply_en || !dq_oe)) begin
      num_errors++;
      $display("MISMATCH t=%0t bad write pin levels", $time);
    end
  end
  initial begin
    seed = 32'hcbec;
    {req_valid, supply_high_req, req_cmd, req_addr, req_data, req_pulse} = '0;
    req_kind = FBCI_OP_IDLE;
    sys_rst = 1'b1;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) sys_rst = 1'b0;
    run(FBCI_OP_IDENT_PIN, 3'h0, 18'h0, 8'h00, 24'h0);
    check(resp_data, flash.MFR_CODE, "pin mfr code");
    run(FBCI_OP_IDENT_PIN, 3'h0, 18'h1, 8'h00, 24'h0);
    check(resp_data, flash.DEV_CODE, "pin dev code");
    run(FBCI_OP_WRITE, 3'h3, 18'h5, 8'h12, 24'h4);
    check({7'h0, resp_err}, 8'h01, "low supply program");
    run(FBCI_OP_WRITE, 3'h2, 18'h5, 8'h00, 24'h4);
    check({7'h0, resp_err}, 8'h01, "low supply erase");
    run(FBCI_OP_READ, 3'h0, 18'h5, 8'h00, 24'h0);
    check(resp_data, 8'hFF, "low supply array");
    $display("Test low supply done");
    supply_high_req = 1'b1;
    repeat (3) @(negedge sys_clk);
    check({7'h0, prog_supply_en}, 8'h01, "supply up");
    run(FBCI_OP_WRITE, 3'h2, 18'h3, 8'h00, 24'h4);
    check({7'h0, resp_err}, 8'h00, "erase");
    run(FBCI_OP_READ, 3'h0, 18'h3, 8'h00, 24'h0);
    check(resp_data, 8'hFF, "erase verify");
    for (int n = 0; n < 4; n++) begin
      alist[n] = ADDR_W'($random(seed));
      req_data = 8'($random(seed));
      if (n == 3) alist[n] = alist[0];
      exp_mem[alist[n]] = exp_rd(alist[n]) & req_data;
      run(FBCI_OP_WRITE, 3'h3, alist[n], req_data, 24'd4 + 24'($random(seed) & 32'h3F));
      check({7'h0, resp_err}, 8'h00, "program");
      run(FBCI_OP_READ, 3'h0, alist[n], 8'h00, 24'h0);
      check(resp_data, exp_rd(alist[n]), "program verify");
    end
    run(FBCI_OP_WRITE, 3'h0, 18'h0, 8'h00, 24'h0);
    for (int n = 0; n < 4; n++) begin
      run(FBCI_OP_READ, 3'h0, alist[n], 8'h00, 24'h0);
      check(resp_data, exp_rd(alist[n]), "array read");
    end
    run(FBCI_OP_WRITE, 3'h1, 18'h0, 8'h00, 24'h0);
    run(FBCI_OP_READ, 3'h0, 18'h0, 8'h00, 24'h0);
    check(resp_data, flash.MFR_CODE, "cmd mfr code");
    run(FBCI_OP_READ, 3'h0, 18'h1, 8'h00, 24'h0);
    check(resp_data, flash.DEV_CODE, "cmd dev code");
    run(FBCI_OP_WRITE, 3'h4, 18'h0, 8'h00, 24'h0);
    run(FBCI_OP_READ, 3'h0, alist[1], 8'h00, 24'h0);
    check(resp_data, exp_rd(alist[1]), "read after reset");
    $display("Test high supply done");
    supply_high_req = 1'b0;
    repeat (3) @(negedge sys_clk);
    check({7'h0, prog_supply_en}, 8'h00, "supply down");
    run(FBCI_OP_READ, 3'h0, alist[2], 8'h00, 24'h0);
    check(resp_data, exp_rd(alist[2]), "read low supply");
    check({7'h0, fault}, 8'h00, "flash pin faults");
    $display("Test supply down done");
    summarize();
  end
endmodule
